// ---- src/cie_top.sv ----
// control input evaluation and safety output control, apb register slave
`timescale 1ns/100ps
`include "cie_defines.svh"

// Notes on behaviour
// - control inputs decode in complementary or one-hot mode, chosen by configuration.
// - complementary pair: 10 gives 0, 01 gives 1, 00 or 11 is error.
// - one-hot: each line alone; single high line selects case by its position.
// - one-hot: no line high or several lines high is an error.
// - configurable input settling delay, default ten milliseconds.
// - up to five dual-channel control inputs may be enabled for case switching.
// - with speed use enabled, speed range joins the monitoring case selection.
// - local safety outputs always switch off with an object in an allocated field; unallocated fields leave them on.
// - a setting picks which external switching output reacts to the field.
// - field status bit is 1 when clear, 0 when interrupted, unallocated always 1.
// - with feedback checking, contactors must drop out; welded contact keeps outputs off.
// - feedback fault without interlock or with delay locks the device out.
// - feedback fault with interlock: outputs off, indicator lit, error code shown.
// - restart mode is none, timed delay, or interlock needing reset.
// - without interlock outputs return as soon as the field is clear.
// - with delay outputs return after the field stays clear for two to sixty seconds.
// - with interlock outputs return only on reset while the field is clear.
module cie_top #(
  parameter int NPAIRS = 5,
  parameter int FIELDS = 4,
  parameter int CLK_PER_MS = `CIE_CLK_HZ / `CIE_HZ_PER_KHZ
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // control input pairs, index 0 is pair a, index 1 pair b
  input wire logic [NPAIRS-1:0] pair_line_one,
  input wire logic [NPAIRS-1:0] pair_line_two,
  input wire logic [1:0] speed_range,
  // scanner and machine side
  input wire logic [FIELDS-1:0] field_object,
  input wire logic contactor_feedback_dropped,
  input wire logic reset_switch,
  // results
  output logic safety_switching_output,
  output logic [3:0] ext_switch_off,
  output logic [FIELDS-1:0] field_status,
  output logic [7:0] monitoring_case,
  output logic case_error,
  output logic fault_led,
  output logic reset_required,
  output logic [7:0] error_code
);
  import cie_pkg::*;

  localparam int NL = 2 * NPAIRS;

  // elaboration-time limits: pair enables sit in five control bits
  if (NPAIRS < 2 || NPAIRS > 5) begin : g_bad_npairs
    $error("cie_top: NPAIRS must be 2..5");
  end
  if (FIELDS < 1 || FIELDS > 8) begin : g_bad_fields
    $error("cie_top: FIELDS must be 1..8");
  end
  if (CLK_PER_MS < 2) begin : g_bad_clk
    $error("cie_top: CLK_PER_MS too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_r;
  logic [15:0] in_delay_r;
  logic [7:0] rst_delay_r;
  logic [FIELDS-1:0] alloc_r;
  logic [31:0] rd_nxt;
  logic hit;
  logic wr_en;
  logic in_stable;
  cie_ctl_if cif ();

  assign wr_en = psel && penable && pready && pwrite;

  always_comb begin
    hit = 1'b1;
    rd_nxt = '0;
    unique case (paddr)
      `CIE_ADDR_CTRL: rd_nxt = ctrl_r;
      `CIE_ADDR_IN_DELAY: rd_nxt = {16'h0000, in_delay_r};
      `CIE_ADDR_RST_DELAY: rd_nxt = {24'h000000, rst_delay_r};
      `CIE_ADDR_FIELD_ALLOC: rd_nxt[FIELDS-1:0] = alloc_r;
      `CIE_ADDR_STATUS: begin
        rd_nxt[`CIE_ST_SAFETY_SWITCHING_OUTPUT] = safety_switching_output;
        rd_nxt[`CIE_ST_CASE_ERR] = case_error;
        rd_nxt[`CIE_ST_RST_REQ] = reset_required;
        rd_nxt[`CIE_ST_FAULT_LED] = fault_led;
        rd_nxt[`CIE_ST_LOCKOUT] = cif.lockout;
        rd_nxt[`CIE_ST_STABLE] = in_stable;
        rd_nxt[`CIE_ST_CASE_HI:`CIE_ST_CASE_LO] = monitoring_case;
        rd_nxt[`CIE_ST_ERR_HI:`CIE_ST_ERR_LO] = error_code;
      end
      `CIE_ADDR_FIELD_STAT: rd_nxt[FIELDS-1:0] = field_status;
      default: hit = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata <= pwrite ? 32'h00000000 : rd_nxt;
        pslverr <= !hit;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `CIE_CTRL_RESET;
      in_delay_r <= `CIE_IN_DELAY_RESET;
      rst_delay_r <= `CIE_RST_DELAY_MIN;
      alloc_r <= {FIELDS{1'b1}};
    end else if (wr_en) begin
      unique case (paddr)
        `CIE_ADDR_CTRL: ctrl_r <= pwdata;
        `CIE_ADDR_IN_DELAY: in_delay_r <= pwdata[15:0];
        `CIE_ADDR_RST_DELAY: begin
          // out-of-range delays clamp so a bad write cannot shorten protection
          if (pwdata[7:0] < `CIE_RST_DELAY_MIN) rst_delay_r <= `CIE_RST_DELAY_MIN;
          else if (pwdata[7:0] > `CIE_RST_DELAY_MAX) rst_delay_r <= `CIE_RST_DELAY_MAX;
          else rst_delay_r <= pwdata[7:0];
        end
        `CIE_ADDR_FIELD_ALLOC: alloc_r <= pwdata[FIELDS-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time base
  logic [31:0] div_r;
  logic [15:0] ms_cnt_r;
  logic ms_tick_r;
  logic sec_tick_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= (div_r == 32'(CLK_PER_MS - 1));
      div_r <= (div_r == 32'(CLK_PER_MS - 1)) ? 32'h00000000 : div_r + 32'h00000001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ms_cnt_r <= '0;
      sec_tick_r <= 1'b0;
    end else begin
      sec_tick_r <= ms_tick_r && (ms_cnt_r == `CIE_MS_PER_S - 16'h0001);
      if (ms_tick_r) begin
        ms_cnt_r <= (ms_cnt_r == `CIE_MS_PER_S - 16'h0001) ? 16'h0000 : ms_cnt_r + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input settling and decode
  logic [NL-1:0] raw_lines;
  logic [NL-1:0] lines;
  logic [NPAIRS-1:0] pair_en;
  logic [7:0] case_nxt;
  logic err_nxt;
  logic [3:0] ones;

  assign pair_en = ctrl_r[`CIE_CTRL_PAIR_LO +: NPAIRS];

  genvar gp;
  generate
    for (gp = 0; gp < NPAIRS; gp++) begin : g_pair
      assign raw_lines[2*gp] = pair_line_one[gp];
      assign raw_lines[2*gp+1] = pair_line_two[gp];
    end
  endgenerate

  cie_input_filter #(
    .W(NL)
  ) u_filter (
    .clk(clk),
    .reset(reset),
    .ms_tick(ms_tick_r),
    .delay_ms(in_delay_r),
    .lines_in(raw_lines),
    .lines_out(lines),
    .stable(in_stable)
  );

  always_comb begin
    case_nxt = '0;
    err_nxt = 1'b0;
    ones = '0;
    if (ctrl_r[`CIE_CTRL_ONEHOT]) begin
      for (int i = 0; i < NL; i++) begin
        if (pair_en[i/2] && lines[i]) begin
          ones = ones + 4'h1;
          case_nxt = 8'(i + 1);
        end
      end
      err_nxt = (ones != 4'h1);
    end else begin
      for (int p = 0; p < NPAIRS; p++) begin
        if (pair_en[p]) begin
          case_nxt[p] = lines[2*p+1];
          if (lines[2*p] == lines[2*p+1]) err_nxt = 1'b1;
        end
      end
    end
    if (ctrl_r[`CIE_CTRL_SPEED]) begin
      case_nxt[6:5] = speed_range;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      monitoring_case <= '0;
      case_error <= 1'b1;
    end else begin
      case_error <= err_nxt;
      if (!err_nxt) monitoring_case <= case_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fields and restart control
  logic obj;
  logic rs_last_r;

  assign obj = |(field_object & alloc_r) || case_error;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      field_status <= {FIELDS{1'b1}};
      ext_switch_off <= '1;
      rs_last_r <= 1'b0;
    end else begin
      field_status <= ~(field_object & alloc_r);
      ext_switch_off <= '0;
      ext_switch_off[ctrl_r[`CIE_CTRL_EXT_HI:`CIE_CTRL_EXT_LO]] <= !cif.safety_switching_output_on;
      rs_last_r <= reset_switch;
    end
  end

  assign cif.obj = obj;
  // an unused mode code behaves as interlock, the safest choice
  assign cif.mode = (ctrl_r[`CIE_CTRL_RST_HI:`CIE_CTRL_RST_LO] > 2'h2) ? CIE_RST_INTERLOCK
                    : cie_rst_mode_t'(ctrl_r[`CIE_CTRL_RST_HI:`CIE_CTRL_RST_LO]);
  assign cif.delay_s = rst_delay_r;
  assign cif.edm_en = ctrl_r[`CIE_CTRL_EDM];
  assign cif.fb_dropped = contactor_feedback_dropped;
  assign cif.reset_pulse = reset_switch && !rs_last_r;
  assign cif.ms_tick = ms_tick_r;
  assign cif.sec_tick = sec_tick_r;

  cie_restart_ctl u_restart (
    .clk(clk),
    .reset(reset),
    .c(cif.ctl)
  );

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      safety_switching_output <= 1'b0;
      fault_led <= 1'b0;
      reset_required <= 1'b0;
      error_code <= `CIE_ERR_NONE;
    end else begin
      safety_switching_output <= cif.safety_switching_output_on && !obj;
      fault_led <= cif.fault_led;
      reset_required <= cif.reset_req;
      if (cif.edm_fault) error_code <= `CIE_ERR_EDM;
      else if (case_error) error_code <= `CIE_ERR_INPUT;
      else error_code <= `CIE_ERR_NONE;
    end
  end
endmodule : cie_top

// ---- src/cie_defines.svh ----
// constants for the control input evaluation and output control block
`ifndef CIE_DEFINES_SVH
`define CIE_DEFINES_SVH
`define CIE_CLK_HZ 100000000
`define CIE_HZ_PER_KHZ 1000
`define CIE_MS_PER_S 16'h03e8
// apb byte addresses
`define CIE_ADDR_CTRL 8'h00
`define CIE_ADDR_IN_DELAY 8'h04
`define CIE_ADDR_RST_DELAY 8'h08
`define CIE_ADDR_FIELD_ALLOC 8'h0c
`define CIE_ADDR_STATUS 8'h10
`define CIE_ADDR_FIELD_STAT 8'h14
// control register fields
`define CIE_CTRL_ONEHOT 0
`define CIE_CTRL_RST_LO 1
`define CIE_CTRL_RST_HI 2
`define CIE_CTRL_EDM 3
`define CIE_CTRL_SPEED 4
`define CIE_CTRL_EXT_LO 5
`define CIE_CTRL_EXT_HI 6
`define CIE_CTRL_PAIR_LO 8
`define CIE_CTRL_RESET 32'h00001f00
// status register fields
`define CIE_ST_SAFETY_SWITCHING_OUTPUT 0
`define CIE_ST_CASE_ERR 1
`define CIE_ST_RST_REQ 2
`define CIE_ST_FAULT_LED 3
`define CIE_ST_LOCKOUT 4
`define CIE_ST_STABLE 5
`define CIE_ST_CASE_LO 8
`define CIE_ST_CASE_HI 15
`define CIE_ST_ERR_LO 16
`define CIE_ST_ERR_HI 23
// timing and limits
`define CIE_IN_DELAY_RESET 16'h000a
`define CIE_RST_DELAY_MIN 8'h02
`define CIE_RST_DELAY_MAX 8'h3c
`define CIE_EDM_MS 16'h012c
// display error codes
`define CIE_ERR_NONE 8'h00
`define CIE_ERR_INPUT 8'h31
`define CIE_ERR_EDM 8'h52
`endif

// ---- src/cie_pkg.sv ----
// types shared by the control input evaluation block
package cie_pkg;
  typedef enum logic [1:0] {
    CIE_RST_NONE,
    CIE_RST_DELAY,
    CIE_RST_INTERLOCK
  } cie_rst_mode_t;

  typedef enum logic [2:0] {
    CIE_S_OFF,
    CIE_S_WAIT,
    CIE_S_ON,
    CIE_S_FAULT,
    CIE_S_LOCK
  } cie_rst_state_t;
endpackage : cie_pkg

// ---- src/cie_ctl_if.sv ----
// link between top and the restart and feedback controller
`timescale 1ns/100ps
interface cie_ctl_if;
  import cie_pkg::*;
  logic obj;
  cie_rst_mode_t mode;
  logic [7:0] delay_s;
  logic edm_en;
  logic fb_dropped;
  logic reset_pulse;
  logic ms_tick;
  logic sec_tick;
  logic safety_switching_output_on;
  logic fault_led;
  logic lockout;
  logic reset_req;
  logic edm_fault;
  modport top (output obj, mode, delay_s, edm_en, fb_dropped, reset_pulse, ms_tick, sec_tick,
               input safety_switching_output_on, fault_led, lockout, reset_req, edm_fault);
  modport ctl (input obj, mode, delay_s, edm_en, fb_dropped, reset_pulse, ms_tick, sec_tick,
               output safety_switching_output_on, fault_led, lockout, reset_req, edm_fault);
endinterface : cie_ctl_if

// ---- src/cie_input_filter.sv ----
// settling filter for the static control lines
`timescale 1ns/100ps
module cie_input_filter #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // timing
  input wire logic ms_tick,
  input wire logic [15:0] delay_ms,
  // lines
  input wire logic [W-1:0] lines_in,
  output logic [W-1:0] lines_out,
  output logic stable
);
  logic [W-1:0] last_r;
  logic [15:0] cnt_r;

  if (W < 2) begin : g_bad_w
    $error("cie_input_filter: W too small");
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      last_r <= '0;
      cnt_r <= '0;
    end else if (lines_in != last_r) begin
      last_r <= lines_in;
      cnt_r <= '0;
    end else if (ms_tick && cnt_r < delay_ms) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lines_out <= '0;
      stable <= 1'b0;
    end else begin
      stable <= (lines_in == last_r) && (cnt_r >= delay_ms);
      if (lines_in == last_r && cnt_r >= delay_ms) begin
        lines_out <= last_r;
      end
    end
  end
endmodule : cie_input_filter

// ---- src/cie_restart_ctl.sv ----
// restart behaviour and contactor feedback supervision
`timescale 1ns/100ps
module cie_restart_ctl (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control link
  cie_ctl_if.ctl c
);
  import cie_pkg::*;
  cie_rst_state_t st_r;
  logic [7:0] sec_r;
  logic [15:0] edm_ms_r;
  logic edm_bad;

  // feedback must show dropped contactors within the window after switch-off
  assign edm_bad = c.edm_en && !c.fb_dropped && edm_ms_r >= `CIE_EDM_MS;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      edm_ms_r <= '0;
    end else if (st_r == CIE_S_ON || c.fb_dropped) begin
      edm_ms_r <= '0;
    end else if (c.ms_tick && edm_ms_r < `CIE_EDM_MS) begin
      edm_ms_r <= edm_ms_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sec_r <= '0;
    end else if (st_r != CIE_S_WAIT || c.obj) begin
      sec_r <= '0;
    end else if (c.sec_tick && sec_r < c.delay_s) begin
      sec_r <= sec_r + 8'h01;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= CIE_S_OFF;
    end else begin
      unique case (st_r)
        CIE_S_ON: begin
          if (c.obj) st_r <= CIE_S_OFF;
        end
        CIE_S_OFF, CIE_S_WAIT: begin
          if (edm_bad) begin
            st_r <= (c.mode == CIE_RST_INTERLOCK) ? CIE_S_FAULT : CIE_S_LOCK;
          end else if (c.obj) begin
            st_r <= CIE_S_OFF;
          end else if (!c.fb_dropped && c.edm_en) begin
            st_r <= st_r;
          end else if (c.mode == CIE_RST_NONE) begin
            st_r <= CIE_S_ON;
          end else if (c.mode == CIE_RST_DELAY) begin
            st_r <= (st_r == CIE_S_WAIT && sec_r >= c.delay_s) ? CIE_S_ON : CIE_S_WAIT;
          end else begin
            st_r <= (st_r == CIE_S_WAIT && c.reset_pulse) ? CIE_S_ON : CIE_S_WAIT;
          end
        end
        CIE_S_FAULT: begin
          if (c.reset_pulse && !c.obj && c.fb_dropped) st_r <= CIE_S_OFF;
        end
        CIE_S_LOCK: begin
          st_r <= CIE_S_LOCK;
        end
        default: st_r <= CIE_S_LOCK;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      c.safety_switching_output_on <= 1'b0;
      c.fault_led <= 1'b0;
      c.lockout <= 1'b0;
      c.reset_req <= 1'b0;
      c.edm_fault <= 1'b0;
    end else begin
      c.safety_switching_output_on <= (st_r == CIE_S_ON) && !c.obj;
      c.fault_led <= (st_r == CIE_S_FAULT);
      c.lockout <= (st_r == CIE_S_LOCK);
      c.reset_req <= (st_r == CIE_S_WAIT) && (c.mode == CIE_RST_INTERLOCK) && !c.obj;
      c.edm_fault <= (st_r == CIE_S_FAULT) || (st_r == CIE_S_LOCK);
    end
  end
endmodule : cie_restart_ctl

// ---- bench/cie_chk.sv ----
// concurrent checks on the ports of the control input evaluation block
`timescale 1ns/100ps
`include "cie_defines.svh"
module cie_chk #(
  parameter int FIELDS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // scanner side
  input wire logic [FIELDS-1:0] field_object,
  // results
  input wire logic safety_switching_output,
  input wire logic [3:0] ext_switch_off,
  input wire logic [FIELDS-1:0] field_status,
  input wire logic case_error,
  input wire logic fault_led,
  input wire logic reset_required,
  input wire logic [7:0] error_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // three cycles of margin cover the registered output path
  sequence err_held; case_error [*3]; endsequence
  sequence field_hit; !(&field_status) [*3]; endsequence
  sequence out_off; !safety_switching_output [*3]; endsequence
  sequence out_on; safety_switching_output [*3]; endsequence
  AST_ERR_OFF: assert property (err_held |-> !safety_switching_output)
    else $error("output on during decode error");
  AST_ERR_CODE: assert property ($rose(case_error) |-> ##[0:2] (error_code != 8'h00))
    else $error("decode error without error code");
  AST_FIELD_OFF: assert property (field_hit |-> !safety_switching_output)
    else $error("output on with field interrupted");
  AST_STAT_CAUSE: assert property ((~field_status & ~($past(field_object) | $past(field_object, 2))) == '0)
    else $error("field status low without object");
  AST_LED: assert property (fault_led [*2] |-> !safety_switching_output && error_code == `CIE_ERR_EDM)
    else $error("feedback fault indication inconsistent");
  AST_EDM_OFF: assert property (error_code == `CIE_ERR_EDM |-> !safety_switching_output)
    else $error("output on during feedback fault");
  AST_RSTREQ: assert property (reset_required |-> !safety_switching_output)
    else $error("output on while reset required");
  AST_EXT_ONE: assert property (!$past(reset) |-> $onehot0(ext_switch_off))
    else $error("more than one external output selected");
  AST_EXT_OFF: assert property (out_off |-> (|ext_switch_off))
    else $error("external output not switched off");
  AST_EXT_ON: assert property (out_on |-> ext_switch_off == 4'h0)
    else $error("external output off while outputs on");
  AST_READY: assert property (pready |-> (psel && penable) ##1 !pready)
    else $error("pready outside access or longer than one cycle");
endmodule : cie_chk

bind cie_top cie_chk #(.FIELDS(FIELDS)) u_chk (.clk(clk), .reset(reset), .psel(psel),
  .penable(penable), .pready(pready), .field_object(field_object),
  .safety_switching_output(safety_switching_output), .ext_switch_off(ext_switch_off),
  .field_status(field_status), .case_error(case_error), .fault_led(fault_led),
  .reset_required(reset_required), .error_code(error_code));

// ---- bench/cie_ctrl_model.sv ----
// machine controller driving the control line pairs, with optional contact bounce
`timescale 1ns/100ps
module cie_ctrl_model (
  // clock
  input wire logic clk,
  // requested condition
  input wire logic [4:0] want_one,
  input wire logic [4:0] want_two,
  input wire logic [7:0] bounce,
  // control lines
  output logic [4:0] pair_line_one,
  output logic [4:0] pair_line_two
);
  logic [9:0] last_r = 10'h000;
  logic [7:0] cnt_r = 8'h00;
  // a relay chatters after each change; delay must outlast it
  always_ff @(posedge clk) begin
    last_r <= {want_one, want_two};
    if (last_r != {want_one, want_two}) cnt_r <= bounce;
    else if (cnt_r != 8'h00) cnt_r <= cnt_r - 8'h01;
  end
  assign pair_line_one = cnt_r[0] ? ~want_one : want_one;
  assign pair_line_two = cnt_r[0] ? ~want_two : want_two;
endmodule : cie_ctrl_model

// ---- bench/cie_top_tb_top.sv ----
// self-checking bench for the control input evaluation block
`timescale 1ns/100ps
`include "cie_defines.svh"
module cie_top_tb_top;
  import cie_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, qe, fb, weld, rsw;
  logic ssd, cerr, led, rreq, oerr;
  logic [7:0] paddr, mcase, ecode, bounce, ocase;
  logic [31:0] pwdata, prdata, q;
  logic [4:0] w1, w2, l1, l2;
  logic [1:0] spd;
  logic [3:0] fobj, ext, fstat;
  logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18};
  logic [31:0] rv [5] = '{`CIE_CTRL_RESET, 32'h0000000a, 32'h00000002, 32'h0000000f, 32'h00000000};
  int fails = 0;
  int n_compared = 0;

  cie_top #(.CLK_PER_MS(10)) dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pair_line_one(l1), .pair_line_two(l2), .speed_range(spd),
    .field_object(fobj), .contactor_feedback_dropped(fb), .reset_switch(rsw),
    .safety_switching_output(ssd), .ext_switch_off(ext), .field_status(fstat),
    .monitoring_case(mcase), .case_error(cerr), .fault_led(led), .reset_required(rreq),
    .error_code(ecode));
  cie_ctrl_model u_ctl (.clk(clk), .want_one(w1), .want_two(w2), .bounce(bounce),
    .pair_line_one(l1), .pair_line_two(l2));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // contactors drop with the outputs unless a weld is simulated
  always @(posedge clk) fb <= !weld && !ssd;

  ////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic stuck;
    chk(32'h0, 32'h1);
    test_done();
  endtask : stuck

  task automatic wt(ref logic s, input logic v, input int n);
    for (int i = 0; i < n && s !== v; i++) @(posedge clk);
    if (s !== v) stuck();
  endtask : wt

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (int i = 0; i < 16 && pready !== 1'h1; i++) @(posedge clk);
    if (pready !== 1'h1) stuck();
    q = prdata;
    qe = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  // h=0 skips the early look where a mode change may re-decode at once
  task automatic settle(input logic [4:0] a, input logic [4:0] b, input logic [7:0] c, input logic e,
                        input logic h);
    w1 <= a;
    w2 <= b;
    repeat (20) @(posedge clk);
    if (h) chk(32'({cerr, mcase}), 32'({oerr, ocase}));
    for (int i = 0; i < 90 && {cerr, mcase} !== {e, c}; i++) @(posedge clk);
    chk(32'({cerr, mcase}), 32'({e, c}));
    if (e) begin
      // error code is registered one cycle behind case_error
      @(posedge clk);
      chk(32'(ecode), 32'(`CIE_ERR_INPUT));
    end
    {oerr, ocase} = {e, c};
  endtask : settle

  task automatic hit;
    fobj <= 4'h1;
    repeat (4) @(posedge clk);
    fobj <= 4'h0;
  endtask : hit

  task automatic press;
    rsw <= 1'h1;
    repeat (3) @(posedge clk);
    rsw <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : press

  ////////////////////////////////////////////////////////////
  initial begin
    {reset, psel, penable, pwrite, rsw, weld, oerr} = 7'h41;
    {paddr, pwdata, w1, w2, bounce, spd, fobj, ocase} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    for (int k = 0; k < 5; k++) begin
      apb(1'h0, ra[k], 32'h0);
      chk(q, rv[k]);
    end
    chk(32'(qe), 32'h1);
    apb(1'h1, 8'h08, 32'h50);
    apb(1'h0, 8'h08, 32'h0);
    chk(q, 32'h3c);
    apb(1'h1, 8'h08, 32'h1);
    apb(1'h0, 8'h08, 32'h0);
    chk(q, 32'h2);
    apb(1'h1, 8'h04, 32'h5);
    apb(1'h0, 8'h04, 32'h0);
    chk(q, 32'h5);
    $display("test registers done");
    settle(5'h0a, 5'h15, 8'h15, 1'h0, 1'h1);
    settle(5'h1d, 5'h02, 8'h02, 1'h0, 1'h1);
    apb(1'h1, 8'h00, 32'h0300);
    settle(5'h02, 5'h01, 8'h01, 1'h0, 1'h0);
    settle(5'h03, 5'h03, 8'h01, 1'h1, 1'h1);
    bounce <= 8'h0a;
    settle(5'h00, 5'h03, 8'h03, 1'h0, 1'h1);
    bounce <= 8'h00;
    settle(5'h00, 5'h00, 8'h03, 1'h1, 1'h1);
    apb(1'h1, 8'h00, 32'h0311);
    spd <= 2'h2;
    settle(5'h01, 5'h00, 8'h41, 1'h0, 1'h0);
    settle(5'h00, 5'h01, 8'h42, 1'h0, 1'h1);
    settle(5'h02, 5'h00, 8'h43, 1'h0, 1'h1);
    settle(5'h00, 5'h02, 8'h44, 1'h0, 1'h1);
    settle(5'h00, 5'h00, 8'h44, 1'h1, 1'h1);
    settle(5'h01, 5'h01, 8'h44, 1'h1, 1'h1);
    settle(5'h01, 5'h00, 8'h41, 1'h0, 1'h1);
    $display("test decode done");
    wt(ssd, 1'h1, 50);
    fobj <= 4'h1;
    repeat (4) @(posedge clk);
    chk(32'({ssd, fstat, ext}), 32'h0e1);
    fobj <= 4'h0;
    repeat (5) @(posedge clk);
    chk(32'(ssd), 32'h1);
    apb(1'h1, 8'h0c, 32'h7);
    apb(1'h1, 8'h00, 32'h0341);
    fobj <= 4'h8;
    repeat (4) @(posedge clk);
    chk(32'({ssd, fstat, ext}), 32'h1f0);
    fobj <= 4'h9;
    repeat (4) @(posedge clk);
    chk(32'({ssd, fstat, ext}), 32'h0e4);
    fobj <= 4'h0;
    apb(1'h1, 8'h00, 32'h0303);
    hit();
    repeat (9000) @(posedge clk);
    chk(32'(ssd), 32'h0);
    wt(ssd, 1'h1, 12000);
    apb(1'h1, 8'h00, 32'h0305);
    fobj <= 4'h1;
    repeat (4) @(posedge clk);
    press();
    fobj <= 4'h0;
    repeat (10) @(posedge clk);
    chk(32'({ssd, rreq}), 32'h1);
    press();
    wt(ssd, 1'h1, 20);
    chk(32'(rreq), 32'h0);
    $display("test restart done");
    apb(1'h1, 8'h00, 32'h030d);
    weld <= 1'h1;
    hit();
    wt(led, 1'h1, 4000);
    chk(32'({ssd, led, ecode}), 32'h152);
    weld <= 1'h0;
    repeat (3) @(posedge clk);
    press();
    wt(led, 1'h0, 50);
    apb(1'h1, 8'h00, 32'h0309);
    wt(ssd, 1'h1, 50);
    weld <= 1'h1;
    hit();
    repeat (3500) @(posedge clk);
    apb(1'h0, 8'h10, 32'h0);
    chk(32'({ssd, q[4], ecode}), 32'h152);
    $display("test feedback done");
    test_done();
  end
endmodule : cie_top_tb_top
